/* File: pld_pkg.sv */
package pld_pkg;
    // ****************
    // Register map
    // ****************
    localparam logic [7:0] PLD_A_CTRL = 8'h00;
    localparam logic [7:0] PLD_A_TRIG = 8'h04;
    localparam logic [7:0] PLD_A_OVTH = 8'h08;
    localparam logic [7:0] PLD_A_DTIME = 8'h0C;
    localparam logic [7:0] PLD_A_DROP = 8'h10;
    localparam logic [7:0] PLD_A_SETPT = 8'h14;
    localparam logic [7:0] PLD_A_UVLV = 8'h18;
    localparam logic [7:0] PLD_A_STAT = 8'h1C;
    localparam logic [7:0] PLD_A_FREQ = 8'h20;
    localparam logic [7:0] PLD_A_ISTAT = 8'h24;
    localparam logic [7:0] PLD_A_IMASK = 8'h28;
    // Control bits
    localparam int PLD_B_EN = 0;
    localparam int PLD_B_RETRY = 1;
    localparam int PLD_B_STOPKEY = 2;
    localparam int PLD_B_RESTART = 3;
    // Interrupt event bits
    localparam int PLD_E_START = 0;
    localparam int PLD_E_DONE = 1;
    localparam int PLD_E_EXHAUST = 2;
    localparam int PLD_E_TRIP = 3;
    localparam int PLD_E_RETRY = 4;
    localparam int PLD_NEV = 5;
    // Widths: volts in 0.1 V, freq in 0.01 Hz, time in 0.01 s
    localparam int PLD_VW = 14;
    localparam int PLD_FW = 16;
    localparam int PLD_TW = 19;
    localparam int PLD_DW = 11;
    localparam int PLD_AW = 40;
    // ****************
    // Reset values
    // ****************
    localparam logic [3:0] PLD_CTRL_RST = 4'h4;
    localparam logic [PLD_VW-1:0] PLD_TRIG_RST = 14'h0C80;
    localparam logic [PLD_VW-1:0] PLD_OVTH_RST = 14'h0DAC;
    localparam logic [PLD_TW-1:0] PLD_DTIME_RST = 19'h003E8;
    localparam logic [PLD_DW-1:0] PLD_DROP_RST = 11'h000;
    localparam logic [PLD_VW-1:0] PLD_UVLV_RST = 14'h0A8C;
    // ****************
    // Timing
    // ****************
    localparam int PLD_CLK_HZ = 20_000_000;
    localparam int PLD_TICK_MS = 10;
    localparam int PLD_TICK_CYC = PLD_CLK_HZ / 1000 * PLD_TICK_MS;
    localparam int PLD_RETRY_MS = 1000;
    localparam int PLD_RETRY_CYC = PLD_CLK_HZ / 1000 * PLD_RETRY_MS;
    localparam int PLD_FMAX = 6000;
    // ****************
    // States
    // ****************
    typedef enum logic [2:0] {
        PLD_ST_STOP = 3'b000,
        PLD_ST_RUN = 3'b001,
        PLD_ST_PLDEC = 3'b010,
        PLD_ST_COAST = 3'b011,
        PLD_ST_TRIP = 3'b100
    } pld_state_e;
endpackage

/* File: pld_power_loss_decel.sv */
`timescale 1ns/1ps
// Operation
// - Enable bit selects controlled deceleration on power loss: 0 off, 1 on.
// - Feature off: power loss drops drive enable at once, motor coasts.
// - Feature on: decel starts when bus voltage falls to trigger level.
// - At decel start, output frequency drops by the initial step.
// - Then frequency ramps down linearly over the power-loss decel time.
// - Bus above over-voltage threshold during decel holds frequency constant.
// - Bus back below threshold resumes the ramp from the held frequency.
// - Hold and resume alternate until bus under-voltage ends the decel.
// - Started decel runs to full stop even if power returns.
// - After power-loss stop with power back, drive is run-enabled again.
// - Feature on changes power-fail and under-voltage indications.
// - Retry mode restarts automatically after a trip stop.
// - After brief outage, drive resumes if run command still active.
// - Alarm reset with run command active restarts the drive.
// - Stop key acts only when its function is enabled.
// - Run command already active at power-up starts the motor.
module pld_power_loss_decel #(
    parameter int FMAX = pld_pkg::PLD_FMAX,
    parameter int TICK_CYC = pld_pkg::PLD_TICK_CYC,
    parameter int RETRY_CYC = pld_pkg::PLD_RETRY_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive inputs
    input wire logic [pld_pkg::PLD_VW-1:0] bus_volt,
    input wire logic power_ok_pin,
    input wire logic run_cmd_pin,
    input wire logic trip_in,
    input wire logic stop_key,
    input wire logic alarm_reset,
    // Modulator and indications
    output logic [pld_pkg::PLD_FW-1:0] freq_out,
    output logic drive_en,
    output logic power_fail,
    output logic undervolt,
    output logic irq
);
    // ****************
    // Pin synchronisers
    // ****************
    logic [1:0] raw;
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;
    logic [1:0] lvl_q;
    assign raw = {run_cmd_pin, power_ok_pin};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    lvl_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    // Glitch filter: change only when two stages agree
                    if (s2_q[gi] == s3_q[gi]) lvl_q[gi] <= s3_q[gi];
                end
            end
        end
    endgenerate
    logic pwr_ok;
    logic run_s;
    assign pwr_ok = lvl_q[0];
    assign run_s = lvl_q[1];
    // ****************
    // Registers
    // ****************
    logic [3:0] ctrl_q;
    logic [pld_pkg::PLD_VW-1:0] trig_q;
    logic [pld_pkg::PLD_VW-1:0] ovth_q;
    logic [pld_pkg::PLD_VW-1:0] uvlv_q;
    logic [pld_pkg::PLD_TW-1:0] dtime_q;
    logic [pld_pkg::PLD_DW-1:0] drop_q;
    logic [pld_pkg::PLD_FW-1:0] setpt_q;
    logic [pld_pkg::PLD_NEV-1:0] istat_q;
    logic [pld_pkg::PLD_NEV-1:0] imask_q;
    logic [pld_pkg::PLD_NEV-1:0] ev_q;
    logic ready_q;
    logic [31:0] rdata_q;
    logic err_q;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction
    logic wr_acc;
    logic setup;
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && ready_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= pld_pkg::PLD_CTRL_RST;
            trig_q <= pld_pkg::PLD_TRIG_RST;
            ovth_q <= pld_pkg::PLD_OVTH_RST;
            uvlv_q <= pld_pkg::PLD_UVLV_RST;
            dtime_q <= pld_pkg::PLD_DTIME_RST;
            drop_q <= pld_pkg::PLD_DROP_RST;
            setpt_q <= 16'h0000;
            imask_q <= 5'h00;
        end else if (wr_acc) begin
            if (hit(paddr, pld_pkg::PLD_A_CTRL)) ctrl_q <= pwdata[3:0];
            if (hit(paddr, pld_pkg::PLD_A_TRIG)) trig_q <= pwdata[pld_pkg::PLD_VW-1:0];
            if (hit(paddr, pld_pkg::PLD_A_OVTH)) ovth_q <= pwdata[pld_pkg::PLD_VW-1:0];
            if (hit(paddr, pld_pkg::PLD_A_UVLV)) uvlv_q <= pwdata[pld_pkg::PLD_VW-1:0];
            if (hit(paddr, pld_pkg::PLD_A_DTIME)) dtime_q <= pwdata[pld_pkg::PLD_TW-1:0];
            if (hit(paddr, pld_pkg::PLD_A_DROP)) drop_q <= pwdata[pld_pkg::PLD_DW-1:0];
            if (hit(paddr, pld_pkg::PLD_A_SETPT)) setpt_q <= pwdata[pld_pkg::PLD_FW-1:0];
            if (hit(paddr, pld_pkg::PLD_A_IMASK)) imask_q <= pwdata[pld_pkg::PLD_NEV-1:0];
        end
    end
    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= 5'h00;
        end else if (wr_acc && hit(paddr, pld_pkg::PLD_A_ISTAT)) begin
            istat_q <= (istat_q & ~pwdata[pld_pkg::PLD_NEV-1:0]) | ev_q;
        end else begin
            istat_q <= istat_q | ev_q;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(istat_q & imask_q);
        end
    end
    // ****************
    // Control state
    // ****************
    pld_pkg::pld_state_e state_q;
    logic [pld_pkg::PLD_AW-1:0] acc_q;
    logic [31:0] retry_q;
    logic block_q;
    logic en;
    logic uv_now;
    logic ov_now;
    logic stop_hit;
    logic run_ok;
    logic retry_due;
    logic [pld_pkg::PLD_FW-1:0] step_f;
    logic [pld_pkg::PLD_AW-1:0] thr;
    logic [pld_pkg::PLD_AW-1:0] sum;
    assign en = ctrl_q[pld_pkg::PLD_B_EN];
    assign uv_now = bus_volt < uvlv_q;
    assign ov_now = bus_volt > ovth_q;
    assign stop_hit = stop_key && ctrl_q[pld_pkg::PLD_B_STOPKEY];
    assign run_ok = run_s && pwr_ok && !trip_in && !block_q;
    assign retry_due = ctrl_q[pld_pkg::PLD_B_RETRY] && (retry_q == 32'(RETRY_CYC - 1));
    assign step_f = (freq_out > 16'(drop_q)) ? freq_out - 16'(drop_q) : 16'h0000;
    assign thr = 40'(dtime_q) * 40'(TICK_CYC);
    assign sum = acc_q + 40'(FMAX);
    // Stop key or a non-restart outage keeps the drive off until run drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_q <= 1'b0;
        end else if ((state_q == pld_pkg::PLD_ST_RUN && stop_hit) ||
                     (state_q == pld_pkg::PLD_ST_COAST && !ctrl_q[pld_pkg::PLD_B_RESTART])) begin
            block_q <= 1'b1;
        end else if (!run_s) begin
            block_q <= 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= pld_pkg::PLD_ST_STOP;
            freq_out <= 16'h0000;
            drive_en <= 1'b0;
            acc_q <= 40'h00_0000_0000;
            retry_q <= 32'h0000_0000;
            ev_q <= 5'h00;
        end else begin
            ev_q <= 5'h00;
            retry_q <= 32'h0000_0000;
            case (state_q)
                pld_pkg::PLD_ST_STOP: begin
                    freq_out <= 16'h0000;
                    drive_en <= 1'b0;
                    acc_q <= 40'h00_0000_0000;
                    if (run_ok) begin
                        state_q <= pld_pkg::PLD_ST_RUN;
                        drive_en <= 1'b1;
                        freq_out <= setpt_q;
                    end
                end
                pld_pkg::PLD_ST_RUN: begin
                    freq_out <= setpt_q;
                    if (trip_in) begin
                        state_q <= pld_pkg::PLD_ST_TRIP;
                        drive_en <= 1'b0;
                        freq_out <= 16'h0000;
                        ev_q[pld_pkg::PLD_E_TRIP] <= 1'b1;
                    end else if (en && bus_volt <= trig_q) begin
                        // Step taken once here, never again in the ramp
                        state_q <= pld_pkg::PLD_ST_PLDEC;
                        freq_out <= step_f;
                        acc_q <= 40'h00_0000_0000;
                        ev_q[pld_pkg::PLD_E_START] <= 1'b1;
                    end else if (!en && !pwr_ok) begin
                        state_q <= pld_pkg::PLD_ST_COAST;
                        drive_en <= 1'b0;
                        freq_out <= 16'h0000;
                        ev_q[pld_pkg::PLD_E_EXHAUST] <= 1'b1;
                    end else if (!run_s || stop_hit) begin
                        state_q <= pld_pkg::PLD_ST_STOP;
                        drive_en <= 1'b0;
                        freq_out <= 16'h0000;
                    end
                end
                pld_pkg::PLD_ST_PLDEC: begin
                    // Run command, stop key and power return ignored here
                    if (uv_now) begin
                        state_q <= pld_pkg::PLD_ST_COAST;
                        drive_en <= 1'b0;
                        freq_out <= 16'h0000;
                        ev_q[pld_pkg::PLD_E_EXHAUST] <= 1'b1;
                    end else if (freq_out == 16'h0000) begin
                        state_q <= pld_pkg::PLD_ST_STOP;
                        drive_en <= 1'b0;
                        ev_q[pld_pkg::PLD_E_DONE] <= 1'b1;
                    end else if (!ov_now) begin
                        // Slopes steeper than one LSB per cycle are clipped
                        if (thr <= 40'(FMAX)) begin
                            acc_q <= 40'h00_0000_0000;
                            freq_out <= freq_out - 16'h0001;
                        end else if (sum >= thr) begin
                            acc_q <= sum - thr;
                            freq_out <= freq_out - 16'h0001;
                        end else begin
                            acc_q <= sum;
                        end
                    end
                end
                pld_pkg::PLD_ST_COAST: begin
                    freq_out <= 16'h0000;
                    drive_en <= 1'b0;
                    if (pwr_ok && !uv_now) state_q <= pld_pkg::PLD_ST_STOP;
                end
                pld_pkg::PLD_ST_TRIP: begin
                    freq_out <= 16'h0000;
                    drive_en <= 1'b0;
                    if (ctrl_q[pld_pkg::PLD_B_RETRY] && !retry_due) begin
                        retry_q <= retry_q + 32'h0000_0001;
                    end
                    if (!trip_in && (alarm_reset || stop_hit || retry_due)) begin
                        state_q <= pld_pkg::PLD_ST_STOP;
                        ev_q[pld_pkg::PLD_E_RETRY] <= retry_due;
                    end
                end
                default: begin
                    state_q <= pld_pkg::PLD_ST_STOP;
                    drive_en <= 1'b0;
                    freq_out <= 16'h0000;
                end
            endcase
        end
    end
    // Indications: with the feature on, power_fail follows the decel and undervolt is masked during it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_fail <= 1'b0;
            undervolt <= 1'b0;
        end else if (en) begin
            power_fail <= (state_q == pld_pkg::PLD_ST_PLDEC);
            undervolt <= uv_now && (state_q != pld_pkg::PLD_ST_PLDEC);
        end else begin
            power_fail <= !pwr_ok;
            undervolt <= uv_now;
        end
    end
    // ****************
    // APB read path
    // ****************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            ready_q <= 1'b1;
            if (setup) begin
                err_q <= 1'b0;
                case (paddr)
                    pld_pkg::PLD_A_CTRL: rdata_q <= 32'(ctrl_q);
                    pld_pkg::PLD_A_TRIG: rdata_q <= 32'(trig_q);
                    pld_pkg::PLD_A_OVTH: rdata_q <= 32'(ovth_q);
                    pld_pkg::PLD_A_DTIME: rdata_q <= 32'(dtime_q);
                    pld_pkg::PLD_A_DROP: rdata_q <= 32'(drop_q);
                    pld_pkg::PLD_A_SETPT: rdata_q <= 32'(setpt_q);
                    pld_pkg::PLD_A_UVLV: rdata_q <= 32'(uvlv_q);
                    pld_pkg::PLD_A_STAT: rdata_q <= 32'({block_q, run_s, pwr_ok, state_q});
                    pld_pkg::PLD_A_FREQ: rdata_q <= 32'(freq_out);
                    pld_pkg::PLD_A_ISTAT: rdata_q <= 32'(istat_q);
                    pld_pkg::PLD_A_IMASK: rdata_q <= 32'(imask_q);
                    default: begin
                        rdata_q <= 32'h0000_0000;
                        err_q <= 1'b1;
                    end
                endcase
            end
        end
    end
    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_disabled_coast: assert property (
        state_q == pld_pkg::PLD_ST_RUN && !trip_in && !en && !pwr_ok
        |=> state_q == pld_pkg::PLD_ST_COAST && !drive_en)
        else $error("power loss with feature off did not coast");
    chk_trigger_start: assert property (
        state_q == pld_pkg::PLD_ST_RUN && !trip_in && en && bus_volt <= trig_q
        |=> state_q == pld_pkg::PLD_ST_PLDEC && power_fail == 1'b0 ##1 power_fail)
        else $error("trigger level did not start decel");
    chk_initial_step: assert property (
        state_q == pld_pkg::PLD_ST_RUN && !trip_in && en && bus_volt <= trig_q
        |=> freq_out == $past(step_f))
        else $error("initial step not applied");
    chk_ramp_monotone: assert property (
        state_q == pld_pkg::PLD_ST_PLDEC ##1 state_q == pld_pkg::PLD_ST_PLDEC
        |-> freq_out <= $past(freq_out) && $past(freq_out) - freq_out <= 16'h0001)
        else $error("decel ramp rose or jumped");
    chk_ov_hold: assert property (
        state_q == pld_pkg::PLD_ST_PLDEC && ov_now && !uv_now && freq_out != 16'h0000
        |=> $stable(freq_out))
        else $error("frequency moved above over-voltage threshold");
    chk_uv_exhaust: assert property (
        state_q == pld_pkg::PLD_ST_PLDEC && uv_now
        |=> state_q == pld_pkg::PLD_ST_COAST && freq_out == 16'h0000)
        else $error("under-voltage did not end decel");
    chk_decel_no_abort: assert property (
        state_q == pld_pkg::PLD_ST_PLDEC && !uv_now && freq_out != 16'h0000
        |=> state_q == pld_pkg::PLD_ST_PLDEC)
        else $error("decel aborted before stop");
    chk_rerun_after: assert property (
        state_q == pld_pkg::PLD_ST_PLDEC && !uv_now && freq_out == 16'h0000 && run_ok
        ##1 run_ok |=> state_q == pld_pkg::PLD_ST_RUN && drive_en)
        else $error("drive not run-enabled after power-loss stop");
    chk_stop_key_off: assert property (
        state_q == pld_pkg::PLD_ST_TRIP && stop_key && !stop_hit && !alarm_reset && !retry_due
        |=> state_q == pld_pkg::PLD_ST_TRIP)
        else $error("disabled stop key cleared trip");
    chk_alarm_restart: assert property (
        state_q == pld_pkg::PLD_ST_TRIP && alarm_reset && !trip_in ##1 run_ok
        |=> state_q == pld_pkg::PLD_ST_RUN)
        else $error("alarm reset with run did not restart");
    chk_irq_level: assert property (
        ##1 irq == |($past(istat_q) & $past(imask_q)))
        else $error("interrupt level wrong");
    cov_pl_stop: cover property (state_q == pld_pkg::PLD_ST_PLDEC ##1
        state_q == pld_pkg::PLD_ST_STOP);
    cov_ov_pause: cover property (state_q == pld_pkg::PLD_ST_PLDEC && ov_now ##1 !ov_now);
    cov_retry: cover property (state_q == pld_pkg::PLD_ST_TRIP && retry_due);
    cov_coast: cover property (state_q == pld_pkg::PLD_ST_COAST);
endmodule

/* File: pld_far_side.sv */
`timescale 1ns/1ps
module pld_far_side (
    // Clock
    input wire logic pclk,
    // Levels requested by the bench
    input wire logic [pld_pkg::PLD_VW-1:0] bus_set,
    input wire logic pwr_set,
    input wire logic run_set,
    // Pins toward the drive
    output logic [pld_pkg::PLD_VW-1:0] bus_volt,
    output logic power_ok_pin,
    output logic run_cmd_pin,
    // Modulator side
    input wire logic [pld_pkg::PLD_FW-1:0] freq_out,
    input wire logic drive_en,
    output logic [pld_pkg::PLD_FW-1:0] motor_freq
);
    // ****************
    // Supply and command source
    // ****************
    // Levels move only just after an edge, like a real sampled source
    always @(posedge pclk) begin
        bus_volt <= bus_set;
        power_ok_pin <= pwr_set;
        run_cmd_pin <= run_set;
    end
    // ****************
    // Modulator
    // ****************
    // Without enable the model drops to zero; no coast dynamics modelled
    always @(posedge pclk) begin
        if (drive_en === 1'b1) begin
            motor_freq <= freq_out;
        end else if (motor_freq !== 16'h0000) begin
            motor_freq <= 16'h0000;
        end
    end
endmodule

/* File: test_pld_power_loss_decel.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module test_pld_power_loss_decel;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, err, pwr_set = 1, run_set = 1, trip_in = 0, stop_key = 0;
    logic alarm_reset = 0, drive_en, power_fail, undervolt, irq;
    logic [13:0] bus_set = 14'h0D00, bus_volt;
    logic power_ok_pin, run_cmd_pin;
    logic [15:0] freq_out, f;
    int failures = 0, tests_run = 0;
    always #25 pclk = ~pclk;
    pld_power_loss_decel #(.TICK_CYC(20), .RETRY_CYC(50)) u_pld_power_loss_decel (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_volt(bus_volt), .power_ok_pin(power_ok_pin), .run_cmd_pin(run_cmd_pin),
        .trip_in(trip_in), .stop_key(stop_key), .alarm_reset(alarm_reset),
        .freq_out(freq_out), .drive_en(drive_en), .power_fail(power_fail),
        .undervolt(undervolt), .irq(irq));
    pld_far_side u_pld_far_side (.pclk(pclk), .bus_set(bus_set), .pwr_set(pwr_set),
        .run_set(run_set), .bus_volt(bus_volt), .power_ok_pin(power_ok_pin),
        .run_cmd_pin(run_cmd_pin), .freq_out(freq_out), .drive_en(drive_en), .motor_freq());
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        rdv = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        if (n >= 50) begin
            failures++;
            $display("mismatch pready expected 1 seen %0h", pready);
            results();
        end
    endtask
    // Mode 0: enable equals v; 1: frequency equals v; 2: frequency leaves v
    task automatic wait_on(input int m, input logic [15:0] v);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (n < 3000 && !((m == 0 && drive_en === v[0]) ||
            (m == 1 && freq_out === v) || (m == 2 && freq_out !== v)));
        if (n >= 3000) begin
            failures++;
            $display("mismatch wait %0d expected %0h seen %0h", m, v, freq_out);
            results();
        end
    endtask
    task automatic pulse(input int k);
        @(posedge pclk);
        if (k == 0) stop_key <= 1; else if (k == 1) alarm_reset <= 1; else trip_in <= 1;
        @(posedge pclk);
        stop_key <= 0; alarm_reset <= 0; trip_in <= 0;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        wait_on(0, 16'h1);
        apb(0, pld_pkg::PLD_A_CTRL, 0); `CHK("ctrl", 32'h4, rdv)
        apb(0, pld_pkg::PLD_A_OVTH, 0); `CHK("ovth", 32'h0DAC, rdv)
        apb(0, pld_pkg::PLD_A_DTIME, 0); `CHK("dtime", 32'h3E8, rdv)
        apb(0, 8'h40, 0); `CHK("unmapped", 1'b1, err)
        apb(1, pld_pkg::PLD_A_SETPT, 32'h3E8);
        apb(1, pld_pkg::PLD_A_DROP, 32'h1F4);
        apb(1, pld_pkg::PLD_A_DTIME, 32'h1);
        apb(1, pld_pkg::PLD_A_CTRL, 32'hD);
        wait_on(1, 16'h03E8);
        $display("test setup done");
        // ****************
        // Controlled ramp with hold and power return
        // ****************
        @(posedge pclk); bus_set <= 14'h0C80; pwr_set <= 0;
        wait_on(2, 16'h03E8); `CHK("first drop", 16'h01F4, freq_out)
        @(negedge pclk);
        `CHK("pf ind", 1'b1, power_fail)
        @(posedge pclk); bus_set <= 14'h0E00;
        repeat (4) @(negedge pclk);
        f = freq_out;
        repeat (10) @(negedge pclk); `CHK("hold", f, freq_out)
        @(posedge pclk); bus_set <= 14'h0B00;
        repeat (6) @(negedge pclk); `CHK("resume", 1'b1, freq_out < f)
        @(posedge pclk); pwr_set <= 1; bus_set <= 14'h0D00;
        repeat (8) @(posedge pclk);
        apb(0, pld_pkg::PLD_A_STAT, 0); `CHK("state", 3'h2, rdv[2:0])
        wait_on(1, 16'h0000);
        wait_on(1, 16'h03E8); `CHK("rerun", 1'b1, drive_en)
        $display("test ramp done");
        apb(0, pld_pkg::PLD_A_ISTAT, 0); `CHK("start ev", 1'b1, rdv[0])
        apb(1, pld_pkg::PLD_A_IMASK, 32'h1);
        repeat (3) @(negedge pclk); `CHK("irq on", 1'b1, irq)
        apb(1, pld_pkg::PLD_A_ISTAT, 32'h1F);
        repeat (3) @(negedge pclk); `CHK("irq off", 1'b0, irq)
        $display("test irq done");
        // ****************
        // Exhaustion, plain outage, stop key, trips
        // ****************
        @(posedge pclk); bus_set <= 14'h0C00;
        wait_on(2, 16'h03E8);
        @(posedge pclk); bus_set <= 14'h0A00;
        wait_on(0, 16'h0);
        @(negedge pclk);
        `CHK("uv ind", 1'b1, undervolt)
        @(posedge pclk); bus_set <= 14'h0D00;
        wait_on(0, 16'h1);
        apb(1, pld_pkg::PLD_A_CTRL, 32'hC);
        @(posedge pclk); pwr_set <= 0;
        wait_on(0, 16'h0); `CHK("pf off", 1'b1, power_fail)
        @(posedge pclk); pwr_set <= 1;
        wait_on(0, 16'h1);
        $display("test outage done");
        apb(1, pld_pkg::PLD_A_CTRL, 32'h8);
        pulse(0);
        repeat (5) @(negedge pclk); `CHK("key off", 1'b1, drive_en)
        apb(1, pld_pkg::PLD_A_CTRL, 32'hC);
        pulse(0);
        wait_on(0, 16'h0);
        @(posedge pclk); run_set <= 0;
        repeat (8) @(posedge pclk);
        run_set <= 1;
        wait_on(0, 16'h1);
        apb(1, pld_pkg::PLD_A_CTRL, 32'h8);
        pulse(2);
        wait_on(0, 16'h0);
        pulse(0);
        repeat (80) @(negedge pclk); `CHK("key trip", 1'b0, drive_en)
        pulse(1);
        wait_on(0, 16'h1);
        apb(1, pld_pkg::PLD_A_CTRL, 32'hA);
        pulse(2);
        wait_on(0, 16'h0);
        wait_on(0, 16'h1);
        $display("test keys done");
        results();
    end
endmodule
